/* File: verilog/vpg_dac_pair_gain.sv */
// volume and fine-trim stage for the two sub-channels of one dac pair
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module vpg_dac_pair_gain
  import vpg_pkg::*;
(
  input  wire logic                       clock,
  input  wire logic                       reset,
  input  wire logic [ADDR_W-1:0]          regAddr,
  input  wire logic [DATA_W-1:0]          regWriteData,
  input  wire logic                       regWrite,
  input  wire logic                       regRead,
  output logic      [DATA_W-1:0]          regReadData,
  input  wire logic                       sampleValidIn,
  input  wire logic signed [SAMPLE_W-1:0] sampleInA,
  input  wire logic signed [SAMPLE_W-1:0] sampleInB,
  output logic                            sampleValidOut,
  output logic signed [SAMPLE_W-1:0]      sampleOutA,
  output logic signed [SAMPLE_W-1:0]      sampleOutB
);

  // ----------------------------------------------------------------
  // lookup tables
  // ----------------------------------------------------------------

  // whole decibels 0..19 dB as linear factors, 16 fraction bits
  function automatic logic [STEP_W-1:0] db_step(
    input logic [TENTH_W-1:0] idx
  );
    logic [STEP_W-1:0] f;
    f = '0;
    unique case (idx)
      11'h000: f = 20'h10000;
      11'h001: f = 20'h11F3D;
      11'h002: f = 20'h14248;
      11'h003: f = 20'h1699C;
      11'h004: f = 20'h195BC;
      11'h005: f = 20'h1C73D;
      11'h006: f = 20'h1FECA;
      11'h007: f = 20'h23D1C;
      11'h008: f = 20'h2830B;
      11'h009: f = 20'h2D182;
      11'h00A: f = 20'h3298B;
      11'h00B: f = 20'h38C52;
      11'h00C: f = 20'h3FB27;
      11'h00D: f = 20'h47782;
      11'h00E: f = 20'h5030A;
      11'h00F: f = 20'h59F98;
      11'h010: f = 20'h64F40;
      11'h011: f = 20'h71458;
      11'h012: f = 20'h7F17B;
      11'h013: f = 20'h8E99A;
      default: f = '0;
    endcase
    return f;
  endfunction : db_step

  // tenths of a decibel 0..0.9 dB, 16 fraction bits
  function automatic logic [FSTEP_W-1:0] tenth_step(
    input logic [TENTH_W-1:0] idx
  );
    logic [FSTEP_W-1:0] f;
    f = '0;
    unique case (idx)
      11'h000: f = 17'h10000;
      11'h001: f = 17'h102F7;
      11'h002: f = 17'h105F7;
      11'h003: f = 17'h108FF;
      11'h004: f = 17'h10C11;
      11'h005: f = 17'h10F2B;
      11'h006: f = 17'h1124F;
      11'h007: f = 17'h1157C;
      11'h008: f = 17'h118B3;
      11'h009: f = 17'h11BF3;
      default: f = '0;
    endcase
    return f;
  endfunction : tenth_step

  // decades from -120 dB to +20 dB, 32 fraction bits
  function automatic logic [DECADE_W-1:0] decade_scale(
    input logic [TENTH_W-1:0] idx
  );
    logic [DECADE_W-1:0] f;
    f = '0;
    unique case (idx)
      11'h000: f = 36'h0000010C7;
      11'h001: f = 36'h00000A7C6;
      11'h002: f = 36'h000068DB9;
      11'h003: f = 36'h000418937;
      11'h004: f = 36'h0028F5C29;
      11'h005: f = 36'h01999999A;
      11'h006: f = 36'h100000000;
      11'h007: f = 36'hA00000000;
      default: f = '0;
    endcase
    return f;
  endfunction : decade_scale

  // ----------------------------------------------------------------
  // code to linear gain
  // ----------------------------------------------------------------

  // position in tenths of a dB, biased so that unity lands on a decade
  // boundary and is therefore exact, not a product of rounded factors
  function automatic logic [GAIN_W-1:0] codes_to_gain(
    input logic [DATA_W-1:0] volume,
    input logic [TRIM_W-1:0] trim
  );
    logic [TENTH_W-1:0]          pos;
    logic [TENTH_W-1:0]          decade;
    logic [TENTH_W-1:0]          rest;
    logic [TENTH_W-1:0]          whole;
    logic [TENTH_W-1:0]          tenth;
    logic [STEP_W+FSTEP_W-1:0]   mant;
    logic [DECADE_W+STEP_W:0]    full;
    pos    = TENTH_W'(volume) * VOL_STEP
           + TENTH_W'(trim)
           + TENTH_BIAS;
    decade = pos / DECADE_TENTHS;
    rest   = pos - decade * DECADE_TENTHS;
    whole  = rest / DB_TENTHS;
    tenth  = rest - whole * DB_TENTHS;
    mant   = db_step(whole) * tenth_step(tenth);
    full   = decade_scale(decade)
           * (DECADE_W+STEP_W+1)'(mant >> TABLE_FRAC);
    return GAIN_W'(full >> TABLE_FRAC);
  endfunction : codes_to_gain

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic              writeVolA;
  logic              writeTrimA;
  logic              writeVolB;
  logic              writeTrimB;
  logic              writeStatus;
  logic [DATA_W-1:0] volumeRegA;
  logic [DATA_W-1:0] trimRegA;
  logic [DATA_W-1:0] volumeRegB;
  logic [DATA_W-1:0] trimRegB;
  logic [DATA_W-1:0] statusWord;
  logic [DATA_W-1:0] regReadData_r;

  // address decode of the write strobe
  assign writeVolA   = regWrite && (regAddr == OFS_A_VOLUME);
  assign writeTrimA  = regWrite && (regAddr == OFS_A_TRIM);
  assign writeVolB   = regWrite && (regAddr == OFS_B_VOLUME);
  assign writeTrimB  = regWrite && (regAddr == OFS_B_TRIM);
  assign writeStatus = regWrite && (regAddr == OFS_STATUS);

  // volume registers, full byte, reset to unity
  vpg_code_reg #(
    .RESET_VALUE (RST_VOLUME),
    .WRITE_MASK  (MASK_VOLUME)
  ) u_vol_a (
    .clock     (clock),
    .reset     (reset),
    .writeEn   (writeVolA),
    .writeData (regWriteData),
    .value     (volumeRegA)
  );

  vpg_code_reg #(
    .RESET_VALUE (RST_VOLUME),
    .WRITE_MASK  (MASK_VOLUME)
  ) u_vol_b (
    .clock     (clock),
    .reset     (reset),
    .writeEn   (writeVolB),
    .writeData (regWriteData),
    .value     (volumeRegB)
  );

  // trim registers: low nibble stays zero even if software slips
  vpg_code_reg #(
    .RESET_VALUE (RST_TRIM),
    .WRITE_MASK  (MASK_TRIM)
  ) u_trim_a (
    .clock     (clock),
    .reset     (reset),
    .writeEn   (writeTrimA),
    .writeData (regWriteData),
    .value     (trimRegA)
  );

  vpg_code_reg #(
    .RESET_VALUE (RST_TRIM),
    .WRITE_MASK  (MASK_TRIM)
  ) u_trim_b (
    .clock     (clock),
    .reset     (reset),
    .writeEn   (writeTrimB),
    .writeData (regWriteData),
    .value     (trimRegB)
  );

  // ----------------------------------------------------------------
  // gain registers
  // ----------------------------------------------------------------
  logic [GAIN_W-1:0] gainA_r;
  logic [GAIN_W-1:0] gainB_r;
  logic              muteA_r;
  logic              muteB_r;

  // registered so the long table path never meets the multiplier
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      gainA_r <= GAIN_UNITY;
      gainB_r <= GAIN_UNITY;
    end
    else
    begin
      gainA_r <= codes_to_gain(volumeRegA,
        trimRegA[TRIM_LSB +: TRIM_W]);
      gainB_r <= codes_to_gain(volumeRegB,
        trimRegB[TRIM_LSB +: TRIM_W]);
    end
  end

  // mute overrides any gain value
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      muteA_r <= 1'b0;
      muteB_r <= 1'b0;
    end
    else
    begin
      muteA_r <= (volumeRegA == MUTE_CODE);
      muteB_r <= (volumeRegB == MUTE_CODE);
    end
  end

  // ----------------------------------------------------------------
  // sample path
  // ----------------------------------------------------------------
  vpg_scale_if scaleA ();
  vpg_scale_if scaleB ();

  assign scaleA.sampleIn = sampleInA;
  assign scaleA.gain     = gainA_r;
  assign scaleA.mute     = muteA_r;
  assign scaleB.sampleIn = sampleInB;
  assign scaleB.gain     = gainB_r;
  assign scaleB.mute     = muteB_r;

  vpg_scaler u_scale_a (
    .port_s (scaleA.scaler)
  );

  vpg_scaler u_scale_b (
    .port_s (scaleB.scaler)
  );

  logic                       sampleValidOut_r;
  logic signed [SAMPLE_W-1:0] sampleOutA_r;
  logic signed [SAMPLE_W-1:0] sampleOutB_r;

  // outputs hold the last result between valid samples
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      sampleValidOut_r <= 1'b0;
      sampleOutA_r     <= '0;
      sampleOutB_r     <= '0;
    end
    else
    begin
      sampleValidOut_r <= sampleValidIn;
      if (sampleValidIn)
      begin
        sampleOutA_r <= scaleA.sampleOut;
        sampleOutB_r <= scaleB.sampleOut;
      end
    end
  end

  // ----------------------------------------------------------------
  // status and read-back
  // ----------------------------------------------------------------
  logic clipA_r;
  logic clipB_r;

  // sticky clip flags, write one to clear; a new clip wins the clear
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      clipA_r <= 1'b0;
      clipB_r <= 1'b0;
    end
    else
    begin
      if (sampleValidIn && scaleA.clip)
        clipA_r <= 1'b1;
      else if (writeStatus && regWriteData[ST_CLIP_A])
        clipA_r <= 1'b0;
      if (sampleValidIn && scaleB.clip)
        clipB_r <= 1'b1;
      else if (writeStatus && regWriteData[ST_CLIP_B])
        clipB_r <= 1'b0;
    end
  end

  // live mute state beside the sticky flags
  always_comb
  begin
    statusWord            = READ_IDLE;
    statusWord[ST_CLIP_A] = clipA_r;
    statusWord[ST_CLIP_B] = clipB_r;
    statusWord[ST_MUTE_A] = muteA_r;
    statusWord[ST_MUTE_B] = muteB_r;
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clock)
  begin
    if (reset)
      regReadData_r <= READ_IDLE;
    else if (regRead)
    begin
      unique case (regAddr)
        OFS_A_VOLUME: regReadData_r <= volumeRegA;
        OFS_A_TRIM:   regReadData_r <= trimRegA;
        OFS_B_VOLUME: regReadData_r <= volumeRegB;
        OFS_B_TRIM:   regReadData_r <= trimRegB;
        OFS_STATUS:   regReadData_r <= statusWord;
        default:      regReadData_r <= READ_IDLE;
      endcase
    end
    else
      regReadData_r <= READ_IDLE;
  end

  assign regReadData    = regReadData_r;
  assign sampleValidOut = sampleValidOut_r;
  assign sampleOutA     = sampleOutA_r;
  assign sampleOutB     = sampleOutB_r;

endmodule : vpg_dac_pair_gain

`default_nettype wire

/* File: shared/vpg_pkg.sv */
// constants shared by the sub-channel volume and fine-trim stage
package vpg_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W      = 8;
  localparam int DATA_W      = 8;
  localparam int SAMPLE_W    = 24;
  localparam int GAIN_W      = 40;
  localparam int GAIN_FRAC   = 32;
  localparam int TENTH_W     = 11;
  localparam int TRIM_W      = 4;
  localparam int TRIM_LSB    = 4;
  localparam int STEP_W      = 20;
  localparam int FSTEP_W     = 17;
  localparam int DECADE_W    = 36;
  localparam int TABLE_FRAC  = 16;

  // ----------------------------------------------------------------
  // register offsets, resets and writable bits
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_A_VOLUME = 8'h6E;
  localparam logic [ADDR_W-1:0] OFS_A_TRIM   = 8'h6F;
  localparam logic [ADDR_W-1:0] OFS_B_VOLUME = 8'h70;
  localparam logic [ADDR_W-1:0] OFS_B_TRIM   = 8'h71;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'hF0;
  localparam logic [DATA_W-1:0] RST_VOLUME   = 8'hC9;
  localparam logic [DATA_W-1:0] RST_TRIM     = 8'h80;
  localparam logic [DATA_W-1:0] MASK_VOLUME  = 8'hFF;
  localparam logic [DATA_W-1:0] MASK_TRIM    = 8'hF0;
  localparam logic [DATA_W-1:0] READ_IDLE    = 8'h00;
  localparam logic [DATA_W-1:0] MUTE_CODE    = 8'h00;

  // status bits
  localparam int ST_CLIP_A = 0;
  localparam int ST_CLIP_B = 1;
  localparam int ST_MUTE_A = 2;
  localparam int ST_MUTE_B = 3;

  // ----------------------------------------------------------------
  // gain arithmetic in tenths of a decibel
  // ----------------------------------------------------------------
  localparam int UNITY_VOL  = 201;
  localparam int UNITY_TRIM = 8;
  localparam int UNITY_POS  = 1200;
  localparam int VOL_TENTHS = 5;
  localparam logic [TENTH_W-1:0] VOL_STEP      = TENTH_W'(VOL_TENTHS);
  localparam logic [TENTH_W-1:0] TENTH_BIAS    =
    TENTH_W'(UNITY_POS - UNITY_VOL * VOL_TENTHS - UNITY_TRIM);
  localparam logic [TENTH_W-1:0] DECADE_TENTHS = 11'h0C8;
  localparam logic [TENTH_W-1:0] DB_TENTHS     = 11'h00A;
  localparam logic [GAIN_W-1:0]  GAIN_UNITY    = 40'h0100000000;

endpackage : vpg_pkg

/* File: shared/vpg_scale_if.sv */
// carrier between the top and one sample scaler
`timescale 1ns/10ps
`default_nettype none

interface vpg_scale_if;
  import vpg_pkg::*;

  logic signed [SAMPLE_W-1:0] sampleIn;
  logic        [GAIN_W-1:0]   gain;
  logic                       mute;
  logic signed [SAMPLE_W-1:0] sampleOut;
  logic                       clip;

  modport source (output sampleIn, gain, mute, input sampleOut, clip);
  modport scaler (input sampleIn, gain, mute, output sampleOut, clip);

endinterface : vpg_scale_if

`default_nettype wire

/* File: verilog/vpg_code_reg.sv */
// one byte-wide configuration register with fixed read-only bits
`timescale 1ns/10ps
`default_nettype none

module vpg_code_reg
  import vpg_pkg::*;
#(
  parameter logic [DATA_W-1:0] RESET_VALUE = RST_VOLUME,
  parameter logic [DATA_W-1:0] WRITE_MASK  = MASK_VOLUME
)
(
  input  wire logic              clock,
  input  wire logic              reset,
  input  wire logic              writeEn,
  input  wire logic [DATA_W-1:0] writeData,
  output logic      [DATA_W-1:0] value
);

  logic [DATA_W-1:0] value_r;

  // read-only bits keep their reset value whatever is written
  always_ff @(posedge clock)
  begin
    if (reset)
      value_r <= RESET_VALUE;
    else if (writeEn)
      value_r <= (writeData & WRITE_MASK) | (RESET_VALUE & ~WRITE_MASK);
  end

  assign value = value_r;

endmodule : vpg_code_reg

`default_nettype wire

/* File: verilog/vpg_scaler.sv */
// multiplies one sample by a linear gain and saturates the result
`timescale 1ns/10ps
`default_nettype none

module vpg_scaler
  import vpg_pkg::*;
(
  vpg_scale_if.scaler port_s
);

  localparam int PROD_W = SAMPLE_W + GAIN_W + 1;
  localparam logic signed [PROD_W-1:0] POS_LIMIT =
    PROD_W'((2 ** (SAMPLE_W - 1)) - 1);
  localparam logic signed [PROD_W-1:0] NEG_LIMIT =
    PROD_W'(-(2 ** (SAMPLE_W - 1)));

  logic signed [PROD_W-1:0] product;
  logic signed [PROD_W-1:0] scaled;

  // ----------------------------------------------------------------
  // scale, then clamp
  // ----------------------------------------------------------------
  // clamping beats wrapping: a wrapped peak is a full-scale click
  always_comb
  begin
    product = PROD_W'(port_s.sampleIn) * $signed({1'b0, port_s.gain});
    scaled  = product >>> GAIN_FRAC;
    port_s.clip = 1'b0;
    if (port_s.mute)
    begin
      port_s.sampleOut = '0;
    end
    else if (scaled > POS_LIMIT)
    begin
      port_s.sampleOut = SAMPLE_W'(POS_LIMIT);
      port_s.clip      = 1'b1;
    end
    else if (scaled < NEG_LIMIT)
    begin
      port_s.sampleOut = SAMPLE_W'(NEG_LIMIT);
      port_s.clip      = 1'b1;
    end
    else
    begin
      port_s.sampleOut = SAMPLE_W'(scaled);
    end
  end

endmodule : vpg_scaler

`default_nettype wire

/* File: test/vpg_gain_asserts.sv */
// property checker for the dac pair volume and trim stage
`timescale 1ns/10ps
`default_nettype none

module vpg_gain_asserts
  import vpg_pkg::*;
(
  input wire logic                       clock,
  input wire logic                       reset,
  input wire logic [ADDR_W-1:0]          regAddr,
  input wire logic [DATA_W-1:0]          regWriteData,
  input wire logic                       regWrite,
  input wire logic                       regRead,
  input wire logic [DATA_W-1:0]          regReadData,
  input wire logic                       sampleValidIn,
  input wire logic signed [SAMPLE_W-1:0] sampleInA,
  input wire logic signed [SAMPLE_W-1:0] sampleInB,
  input wire logic                       sampleValidOut,
  input wire logic signed [SAMPLE_W-1:0] sampleOutA,
  input wire logic signed [SAMPLE_W-1:0] sampleOutB
);
  // ----------------------------------------------------------------
  // register mirror and properties
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] volA_r;
  logic [DATA_W-1:0] volB_r;
  logic [TRIM_W-1:0] trimA_r;
  logic [TRIM_W-1:0] trimB_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  // mirror of software writes, reference for reads and gain
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      volA_r  <= RST_VOLUME;
      volB_r  <= RST_VOLUME;
      trimA_r <= RST_TRIM[7:4];
      trimB_r <= RST_TRIM[7:4];
    end
    else if (regWrite)
    begin
      case (regAddr)
        OFS_A_VOLUME: volA_r  <= regWriteData;
        OFS_A_TRIM:   trimA_r <= regWriteData[7:4];
        OFS_B_VOLUME: volB_r  <= regWriteData;
        OFS_B_TRIM:   trimB_r <= regWriteData[7:4];
        default: ;
      endcase
    end
  end

  property p_rd_vol_a;
    regRead && regAddr == OFS_A_VOLUME |=> regReadData == $past(volA_r);
  endproperty
  a_rd_vol_a: assert property (p_rd_vol_a)
    else $error("volume A read back wrong");

  property p_rd_vol_b;
    regRead && regAddr == OFS_B_VOLUME |=> regReadData == $past(volB_r);
  endproperty
  a_rd_vol_b: assert property (p_rd_vol_b)
    else $error("volume B read back wrong");

  property p_rd_trim_a;
    regRead && regAddr == OFS_A_TRIM
      |=> regReadData == {$past(trimA_r), 4'h0};
  endproperty
  a_rd_trim_a: assert property (p_rd_trim_a)
    else $error("trim A read back wrong");

  property p_rd_trim_b;
    regRead && regAddr == OFS_B_TRIM
      |=> regReadData == {$past(trimB_r), 4'h0};
  endproperty
  a_rd_trim_b: assert property (p_rd_trim_b)
    else $error("trim B read back wrong");

  // output valid is the input valid delayed by exactly one edge
  property p_valid_lat;
    sampleValidOut == $past(sampleValidIn);
  endproperty
  a_valid_lat: assert property (p_valid_lat)
    else $error("output valid not one cycle after input");

  property p_mute;
    sampleValidIn && volA_r == MUTE_CODE && $past(volA_r) == MUTE_CODE
      |=> sampleOutA == 24'h000000 [*2];
  endproperty
  a_mute: assert property (p_mute)
    else $error("muted sub-channel A not zero");

  property p_unity;
    sampleValidIn && volB_r == 8'hC9 && $past(volB_r) == 8'hC9
      && trimB_r == 4'h8 && $past(trimB_r) == 4'h8
      |=> sampleOutB == $past(sampleInB);
  endproperty
  a_unity: assert property (p_unity)
    else $error("unity gain not exact on B");

  property p_sat;
    sampleValidIn && volA_r == 8'hFF && $past(volA_r) == 8'hFF
      && sampleInA == 24'sh7FFFFF |=> sampleOutA == 24'sh7FFFFF;
  endproperty
  a_sat: assert property (p_sat)
    else $error("positive full scale did not saturate");

  property p_hold;
    !sampleValidIn |=> $stable(sampleOutA) && $stable(sampleOutB);
  endproperty
  a_hold: assert property (p_hold)
    else $error("sample output moved without valid");

  c_mute: cover property (p_mute);
  c_unity: cover property (p_unity);
  c_sat: cover property (p_sat);

endmodule : vpg_gain_asserts

`default_nettype wire

/* File: test/tb.sv */
// self-checking bench for the dac pair volume and trim stage
`timescale 1ns/10ps
`default_nettype none

bind vpg_dac_pair_gain vpg_gain_asserts i_vpg_gain_asserts (
  .clock(clock), .reset(reset), .regAddr(regAddr),
  .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
  .regReadData(regReadData), .sampleValidIn(sampleValidIn),
  .sampleInA(sampleInA), .sampleInB(sampleInB),
  .sampleValidOut(sampleValidOut), .sampleOutA(sampleOutA),
  .sampleOutB(sampleOutB));

module tb;
  import vpg_pkg::*;
  // ----------------------------------------------------------------
  // stimulus, tasks and sequence
  // ----------------------------------------------------------------
  localparam logic signed [23:0] IN_A = 24'sh04A5A5;
  localparam logic signed [23:0] IN_B = 24'shFB5A5B;
  logic              clock;
  logic              reset;
  logic [7:0]        regAddr;
  logic [7:0]        regWriteData;
  logic              regWrite;
  logic              regRead;
  logic [7:0]        regReadData;
  logic              sampleValidIn;
  logic signed [23:0] sampleInA;
  logic signed [23:0] sampleInB;
  logic              sampleValidOut;
  logic signed [23:0] sampleOutA;
  logic signed [23:0] sampleOutB;
  logic [23:0]       oa;
  logic [23:0]       ob;
  logic [7:0]        volTab [6] = '{8'h01, 8'h02, 8'hCA, 8'hFE, 8'hFF, 8'h00};
  logic [3:0]        trimTab [6] = '{4'h0, 4'h1, 4'hE, 4'hF, 4'h8, 4'h8};
  int                bad_count = 0;
  int                checks_done = 0;
  int                cycleCount = 0;

  vpg_dac_pair_gain i_vpg_dac_pair_gain (
    .clock(clock), .reset(reset), .regAddr(regAddr),
    .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
    .regReadData(regReadData), .sampleValidIn(sampleValidIn),
    .sampleInA(sampleInA), .sampleInB(sampleInB),
    .sampleValidOut(sampleValidOut), .sampleOutA(sampleOutA),
    .sampleOutB(sampleOutB));

  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task end_sim;
    if (bad_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  // run should end within a few hundred cycles
  always @(posedge clock)
  begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == 3000)
    begin
      bad_count = bad_count + 1;
      end_sim();
    end
  end

  // near compares allow the table rounding of the gain factors
  task chk(input logic [23:0] seen, input logic [23:0] exp, input bit near);
    int d;
    int tol;
    d = int'($signed(seen)) - int'($signed(exp));
    tol = near ? 2 + (d < 0 ? 0 : 0) + int'($signed(exp)) / 1500 : 0;
    if (tol < 0)
      tol = -tol + 2;
    checks_done++;
    if ($isunknown(seen) || d > tol || d < -tol)
    begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regWrite     <= 1'b1;
    regAddr      <= a;
    regWriteData <= d;
    @(posedge clock);
    regWrite     <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    chk({16'h0000, regReadData}, {16'h0000, exp}, 1'b0);
  endtask : rd

  task smp(input logic [23:0] a, input logic [23:0] b,
           output logic [23:0] qa, output logic [23:0] qb);
    @(posedge clock);
    sampleValidIn <= 1'b1;
    sampleInA     <= a;
    sampleInB     <= b;
    @(posedge clock);
    sampleValidIn <= 1'b0;
    #1;
    chk({23'h000000, sampleValidOut}, 24'h000001, 1'b0);
    qa = sampleOutA;
    qb = sampleOutB;
  endtask : smp

  // ideal gain from the code steps, floored and saturated
  function automatic logic [23:0] expect_out(input int x, input int v,
                                             input int t);
    real y;
    if (v == 0)
      return 24'h000000;
    y = $floor(x * 10.0 ** (((v - 201) * 0.5 + (t - 8) * 0.1) / 20.0));
    if (y > 8388607.0)
      y = 8388607.0;
    if (y < -8388608.0)
      y = -8388608.0;
    return 24'($rtoi(y));
  endfunction : expect_out

  initial
  begin
    reset = 1'b1;
    regAddr = 8'h00;
    regWriteData = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    sampleValidIn = 1'b0;
    sampleInA = 24'sh000000;
    sampleInB = 24'sh000000;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    rd(OFS_A_VOLUME, 8'hC9);
    rd(OFS_A_TRIM, 8'h80);
    rd(OFS_B_VOLUME, 8'hC9);
    rd(OFS_B_TRIM, 8'h80);
    rd(8'h55, 8'h00);
    smp(IN_A, IN_B, oa, ob);
    chk(oa, IN_A, 1'b0);
    chk(ob, IN_B, 1'b0);
    // read-only low trim bits ignore a full write
    wr(OFS_A_VOLUME, 8'h5A);
    wr(OFS_A_TRIM, 8'hFF);
    wr(OFS_B_VOLUME, 8'hA5);
    wr(OFS_B_TRIM, 8'h3C);
    rd(OFS_A_VOLUME, 8'h5A);
    rd(OFS_A_TRIM, 8'hF0);
    rd(OFS_B_VOLUME, 8'hA5);
    rd(OFS_B_TRIM, 8'h30);
    // code table, A and B set apart each time
    for (int i = 0; i < 6; i++)
    begin
      wr(OFS_A_VOLUME, volTab[i]);
      wr(OFS_A_TRIM, {trimTab[i], 4'h0});
      wr(OFS_B_VOLUME, volTab[5 - i]);
      wr(OFS_B_TRIM, {trimTab[(i + 3) % 6], 4'h0});
      smp(IN_A, IN_B, oa, ob);
      chk(oa, expect_out(int'(IN_A), int'(volTab[i]), int'(trimTab[i])),
          1'b1);
      chk(ob, expect_out(int'(IN_B), int'(volTab[5 - i]),
          int'(trimTab[(i + 3) % 6])), 1'b1);
    end
    // new gain must reach the very next legal sample
    wr(OFS_A_VOLUME, 8'hC9);
    smp(IN_A, IN_B, oa, ob);
    chk(oa, IN_A, 1'b0);
    wr(OFS_A_VOLUME, MUTE_CODE);
    smp(IN_A, IN_B, oa, ob);
    chk(oa, 24'h000000, 1'b0);
    // full boost drives both rails into saturation
    wr(OFS_A_VOLUME, 8'hFF);
    wr(OFS_B_VOLUME, 8'hFF);
    smp(24'h7FFFFF, 24'h800000, oa, ob);
    chk(oa, 24'h7FFFFF, 1'b0);
    chk(ob, 24'h800000, 1'b0);
    rd(OFS_STATUS, 8'h03);
    wr(OFS_STATUS, 8'h03);
    rd(OFS_STATUS, 8'h00);
    end_sim();
  end

endmodule : tb

`default_nettype wire
